// ===== hw/sad_addr_map.sv
// Purpose: Combinational address map with bit-band alias translation
// Assumes: Address is a 32-bit byte address
// Notes:   Translated alias address is decoded again like a direct one
`timescale 1ns/1ps
`default_nettype none
module sad_addr_map
   import sad_pkg::*;
(
   input  wire logic [31:0] addr,   // Byte address from master
   output sad_pkg::sad_map_t map    // Decoded target and offset
);
   logic [31:0] phys;
   logic [19:0] boff;

   always_comb begin
      map            = '0;
      map.sel        = SEL_NONE;
      phys           = addr;
      boff           = addr[24:5];
      if (addr >= SRAM_AL_LO && addr <= SRAM_AL_HI) begin
         map.alias_hit = 1'b1;
         phys          = SRAM_BASE | {12'h000, boff[19:2], 2'b00};
         map.bitpos    = {boff[1:0], addr[4:2]};
      end else if (addr >= PERI_AL_LO && addr <= PERI_AL_HI) begin
         map.alias_hit = 1'b1;
         phys          = PERI_BASE | {12'h000, boff[19:2], 2'b00};
         map.bitpos    = {boff[1:0], addr[4:2]};
      end
      // Fixed map over the full 4 GB space
      if (phys[31:18] == FLASH_HI) begin
         map.sel    = SEL_FLASH;
         map.offset = phys[19:0] & OFS_FLASH_M;
      end else if (phys[31:16] == SRAM_HI) begin
         map.sel    = SEL_SRAM;
         map.offset = phys[19:0] & OFS_SRAM_M;
      end else begin
         map.offset = phys[19:0] & OFS_SLOT_M;
         if (phys[31:20] == PERI_HI)
            map.sel = peri_slot(phys[19:12]);
         else if (phys[31:12] == SWT_SLOT)
            map.sel = SEL_SWTRACE;
         else if (phys[31:12] == WPT_SLOT)
            map.sel = SEL_WPTRACE;
         else if (phys[31:12] == PBU_SLOT)
            map.sel = SEL_PATCHBP;
         else if (phys[31:12] == CORE_SLOT)
            map.sel = SEL_COREPER;
         else if (phys[31:12] == TPU_SLOT)
            map.sel = SEL_TRACEPORT;
      end
      map.fault = (map.sel == SEL_NONE);
   end
endmodule
`default_nettype wire

// ===== hw/sad_decoder.sv
// Purpose: System address decoder between the core and its memory targets
// Assumes: Targets answer with a one-cycle ack on the system clock
// Notes:   Alias writes hold tgt_lock over the read and the write back
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Operation
// - Reserved addresses end in an error response, no target is accessed.
// - Fixed 4 GB map over 32-bit byte addresses, never remapped.
// - Byte lanes are little endian, lowest address in the lowest byte.
// - Byte, halfword and word sizes accepted; master marks each size.
// - A word-aligned 64-bit transfer outside the alias windows becomes two word accesses at consecutive addresses.
// - SRAM alias window maps to single bits of SRAM words.
// - Peripheral alias window maps to single bits of lower peripheral space.
// - Alias write is a locked read-modify-write; alias read returns the addressed bit in bit 0.
// - Peripherals selected by base; low bits sent as register offset.
// - Bottom private-bus slots go to trace, watchpoint, patch units.
// - System control window goes to the core peripherals.
// - Trace port window routed; private-bus space above it is reserved.
module sad_decoder
   import sad_pkg::*;
(
   input  wire logic             clk,        // System clock
   input  wire logic             rst,        // Asynchronous reset, high
   input  wire logic             req_valid,  // Master request present
   input  wire sad_pkg::sad_req_t req,       // Master request
   output logic                  req_ready,  // Request taken when high
   output logic                  rsp_valid,  // Response pulse
   output sad_pkg::sad_rsp_t     rsp,        // Response data and error
   output logic                  tgt_valid,  // Target access pending
   output sad_pkg::sad_tgt_t     tgt,        // Target access
   output logic                  tgt_lock,   // Locked sequence in progress
   input  wire logic             tgt_ack,    // Target done, one cycle
   input  wire logic [31:0]      tgt_rdata,  // Target read data
   input  wire logic             tgt_err     // Target error with ack
);
   import sad_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ACC  = 3'b001,
      S_RESP = 3'b011,
      S_HI   = 3'b111,
      S_RMW  = 3'b101
   } sad_st_t;

   sad_st_t   st_r, st_nxt;
   sad_req_t  cur_r, cur_nxt;
   sad_map_t  map_r, map_nxt, map_in;
   sad_tgt_t  tgt_r, tgt_nxt;
   sad_rsp_t  rsp_r, rsp_nxt;
   logic      tv_r, tv_nxt, lock_r, lock_nxt, rv_r, rv_nxt, rdy_r, rdy_nxt;
   logic      misal;

   sad_addr_map u_map (
      .addr (req.addr),
      .map  (map_in)
   );

   //////////////////////////////////////////////////////////////////////////
   // Lane helpers
   function automatic logic [3:0] lane_strb(input logic [1:0] sz, input logic [1:0] a);
      unique case (sz)
         SZ_BYTE: lane_strb = 4'h1 << a;
         SZ_HALF: lane_strb = 4'h3 << a;
         default: lane_strb = 4'hf;
      endcase
   endfunction

   function automatic logic [31:0] lane_rd(input logic [1:0] sz, input logic [1:0] a,
                                           input logic [31:0] d);
      logic [31:0] s;
      s = d >> {a, 3'b000};
      unique case (sz)
         SZ_BYTE: lane_rd = {24'h000000, s[7:0]};
         SZ_HALF: lane_rd = {16'h0000, s[15:0]};
         default: lane_rd = s;
      endcase
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_nxt   = st_r;
      cur_nxt  = cur_r;
      map_nxt  = map_r;
      tgt_nxt  = tgt_r;
      rsp_nxt  = rsp_r;
      tv_nxt   = tv_r;
      lock_nxt = lock_r;
      rdy_nxt  = rdy_r;
      rv_nxt   = 1'b0;
      misal    = ((req.size == SZ_HALF) && req.addr[0]) ||
                 (req.size[1] && (req.addr[1:0] != 2'b00));
      unique case (st_r)
         S_IDLE: begin
            if (req_valid && rdy_r) begin
               cur_nxt = req;
               map_nxt = map_in;
               rdy_nxt = 1'b0;
               if (map_in.fault || (misal && !map_in.alias_hit)) begin
                  rsp_nxt = '{err: 1'b1, rdata: 64'h0};
                  rv_nxt  = 1'b1;
                  st_nxt  = S_RESP;
               end else begin
                  tgt_nxt.sel    = map_in.sel;
                  tgt_nxt.offset = map_in.offset;
                  if (map_in.alias_hit) begin
                     tgt_nxt.write = 1'b0;
                     tgt_nxt.strb  = 4'hf;
                     tgt_nxt.wdata = 32'h0;
                     lock_nxt      = req.write;
                  end else begin
                     tgt_nxt.write = req.write;
                     tgt_nxt.strb  = lane_strb(req.size, req.addr[1:0]);
                     tgt_nxt.wdata = req.wdata[31:0] << {req.addr[1:0], 3'b000};
                  end
                  tv_nxt = 1'b1;
                  st_nxt = S_ACC;
               end
            end else begin
               rdy_nxt = 1'b1;
            end
         end
         S_ACC: begin
            if (tgt_ack) begin
               tv_nxt = 1'b0;
               if (tgt_err) begin
                  rsp_nxt  = '{err: 1'b1, rdata: 64'h0};
                  lock_nxt = 1'b0;
                  rv_nxt   = 1'b1;
                  st_nxt   = S_RESP;
               end else if (map_r.alias_hit && cur_r.write) begin
                  tgt_nxt.write = 1'b1;
                  tgt_nxt.wdata = tgt_rdata;
                  tgt_nxt.wdata[map_r.bitpos] = cur_r.wdata[0];
                  tv_nxt        = 1'b1;
                  st_nxt        = S_RMW;
               end else if (map_r.alias_hit) begin
                  rsp_nxt = '{err: 1'b0, rdata: {63'h0, tgt_rdata[map_r.bitpos]}};
                  rv_nxt  = 1'b1;
                  st_nxt  = S_RESP;
               end else if (cur_r.size == SZ_DWORD) begin
                  rsp_nxt.err         = 1'b0;
                  rsp_nxt.rdata       = {32'h0, tgt_rdata};
                  tgt_nxt.offset      = tgt_r.offset + {17'h0, DW_STEP};
                  tgt_nxt.wdata       = cur_r.wdata[63:32];
                  tv_nxt              = 1'b1;
                  st_nxt              = S_HI;
               end else begin
                  rsp_nxt.err   = 1'b0;
                  rsp_nxt.rdata = {32'h0, lane_rd(cur_r.size, cur_r.addr[1:0], tgt_rdata)};
                  rv_nxt        = 1'b1;
                  st_nxt        = S_RESP;
               end
            end
         end
         S_HI: begin
            if (tgt_ack) begin
               tv_nxt              = 1'b0;
               rsp_nxt.err         = tgt_err;
               rsp_nxt.rdata[63:32] = tgt_rdata;
               rv_nxt              = 1'b1;
               st_nxt              = S_RESP;
            end
         end
         S_RMW: begin
            if (tgt_ack) begin
               tv_nxt   = 1'b0;
               lock_nxt = 1'b0;
               rsp_nxt  = '{err: tgt_err, rdata: 64'h0};
               rv_nxt   = 1'b1;
               st_nxt   = S_RESP;
            end
         end
         S_RESP: begin
            rdy_nxt = 1'b1;
            st_nxt  = S_IDLE;
         end
         default: begin
            tv_nxt   = 1'b0;
            lock_nxt = 1'b0;
            rdy_nxt  = 1'b1;
            st_nxt   = S_IDLE;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r   <= S_IDLE;
         cur_r  <= '0;
         map_r  <= '0;
         tgt_r  <= '0;
         rsp_r  <= '0;
         tv_r   <= 1'b0;
         lock_r <= 1'b0;
         rv_r   <= 1'b0;
         rdy_r  <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         cur_r  <= cur_nxt;
         map_r  <= map_nxt;
         tgt_r  <= tgt_nxt;
         rsp_r  <= rsp_nxt;
         tv_r   <= tv_nxt;
         lock_r <= lock_nxt;
         rv_r   <= rv_nxt;
         rdy_r  <= rdy_nxt;
      end
   end

   assign req_ready = rdy_r;
   assign rsp_valid = rv_r;
   assign rsp       = rsp_r;
   assign tgt_valid = tv_r;
   assign tgt       = tgt_r;
   assign tgt_lock  = lock_r;

   //////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_take_fault;
      req_valid && req_ready && map_in.fault;
   endsequence
   sequence s_fault_out;
      rsp_valid && rsp.err && !tgt_valid;
   endsequence
   property p_fault;
      s_take_fault |=> s_fault_out ##1 (req_ready && !rsp_valid);
   endproperty
   a_fault: assert property (p_fault) else $error("reserved access not faulted");

   property p_ppb_top;
      (req_valid && req.addr > 32'he004_0fff) |-> map_in.fault;
   endproperty
   a_ppb_top: assert property (p_ppb_top) else $error("space above trace port open");

   property p_byte_lane;
      (tgt_valid && !map_r.alias_hit && cur_r.size == SZ_BYTE)
         |-> tgt.strb == (4'h1 << cur_r.addr[1:0]);
   endproperty
   a_byte_lane: assert property (p_byte_lane) else $error("byte lane wrong");

   property p_size_rd;
      (rsp_valid && !rsp.err && !cur_r.write && cur_r.size == SZ_HALF)
         |-> rsp.rdata[63:16] == 48'h0;
   endproperty
   a_size_rd: assert property (p_size_rd) else $error("half read not narrowed");

   property p_dword;
      (st_r == S_ACC && tgt_ack && !tgt_err && !map_r.alias_hit && cur_r.size == SZ_DWORD)
         |=> tgt_valid && tgt.offset == $past(tgt.offset) + 20'h4;
   endproperty
   a_dword: assert property (p_dword) else $error("second word not next address");

   property p_alias_rd;
      (rsp_valid && map_r.alias_hit && !cur_r.write) |-> rsp.rdata[63:1] == 63'h0;
   endproperty
   a_alias_rd: assert property (p_alias_rd) else $error("alias read not one bit");

   sequence s_rmw_rd;
      st_r == S_ACC && map_r.alias_hit && cur_r.write && tgt_ack && !tgt_err;
   endsequence
   property p_rmw;
      s_rmw_rd |=> tgt_valid && tgt.write && tgt_lock &&
         ((tgt.wdata ^ $past(tgt_rdata)) & ~(32'h1 << map_r.bitpos)) == 32'h0;
   endproperty
   a_rmw: assert property (p_rmw) else $error("alias write touched other bits");

   property p_lock;
      (st_r == S_RMW) |-> tgt_lock;
   endproperty
   a_lock: assert property (p_lock) else $error("lock dropped inside rmw");

   property p_sram_alias;
      (req_valid && req_ready && req.addr[31:21] == 11'h110) |=> tgt_valid && tgt.sel == SEL_SRAM;
   endproperty
   a_sram_alias: assert property (p_sram_alias) else $error("sram alias misrouted");

   property p_slot_ofs;
      (tgt_valid && tgt.sel != SEL_FLASH && tgt.sel != SEL_SRAM) |-> tgt.offset[19:12] == 8'h0;
   endproperty
   a_slot_ofs: assert property (p_slot_ofs) else $error("slot offset too wide");
endmodule
`default_nettype wire

// ===== hw/sad_pkg.sv
// Purpose: Shared types and constants for the system address decoder
// Assumes: 32-bit byte addresses, single system clock
// Notes:   Slot indices are address bits [19:12] inside the peripheral area
package sad_pkg;
   localparam int          ADDR_W        = 32;
   localparam logic [1:0]  SZ_BYTE       = 2'h0;
   localparam logic [1:0]  SZ_HALF       = 2'h1;
   localparam logic [1:0]  SZ_WORD       = 2'h2;
   localparam logic [1:0]  SZ_DWORD      = 2'h3;
   localparam logic [31:0] FLASH_BASE    = 32'h0000_0000;
   localparam logic [13:0] FLASH_HI      = 14'h0000;
   localparam logic [15:0] SRAM_HI       = 16'h2000;
   localparam logic [31:0] SRAM_BASE     = 32'h2000_0000;
   localparam logic [31:0] SRAM_AL_LO    = 32'h2200_0000;
   localparam logic [31:0] SRAM_AL_HI    = 32'h221f_ffff;
   localparam logic [11:0] PERI_HI       = 12'h400;
   localparam logic [31:0] PERI_BASE     = 32'h4000_0000;
   localparam logic [31:0] PERI_AL_LO    = 32'h4200_0000;
   localparam logic [31:0] PERI_AL_HI    = 32'h43ff_ffff;
   localparam logic [19:0] SWT_SLOT      = 20'he0000;
   localparam logic [19:0] WPT_SLOT      = 20'he0001;
   localparam logic [19:0] PBU_SLOT      = 20'he0002;
   localparam logic [19:0] CORE_SLOT     = 20'he000e;
   localparam logic [19:0] TPU_SLOT      = 20'he0040;
   localparam logic [19:0] OFS_FLASH_M   = 20'h3ffff;
   localparam logic [19:0] OFS_SRAM_M    = 20'h0ffff;
   localparam logic [19:0] OFS_SLOT_M    = 20'h00fff;
   localparam logic [2:0]  DW_STEP       = 3'h4;

   typedef enum logic [4:0] {
      SEL_NONE, SEL_FLASH, SEL_SRAM, SEL_WDT0, SEL_GPIOA, SEL_GPIOB, SEL_GPIOC,
      SEL_GPIOD, SEL_SSI0, SEL_UART0, SEL_UART1, SEL_UART2, SEL_I2C0, SEL_GPIOE,
      SEL_GPIOF, SEL_GPIOG, SEL_TMR0, SEL_TMR1, SEL_TMR2, SEL_TMR3, SEL_ADC0,
      SEL_ACMP, SEL_HIB, SEL_FCTL, SEL_SYSCTL, SEL_SWTRACE, SEL_WPTRACE,
      SEL_PATCHBP, SEL_COREPER, SEL_TRACEPORT
   } sad_sel_t;

   typedef struct packed {
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [63:0] wdata;
   } sad_req_t;

   typedef struct packed {
      logic        err;
      logic [63:0] rdata;
   } sad_rsp_t;

   typedef struct packed {
      sad_sel_t    sel;
      logic [19:0] offset;
      logic        write;
      logic [3:0]  strb;
      logic [31:0] wdata;
   } sad_tgt_t;

   typedef struct packed {
      sad_sel_t    sel;
      logic        fault;
      logic        alias_hit;
      logic [4:0]  bitpos;
      logic [19:0] offset;
   } sad_map_t;

   // Peripheral slot lookup, one 4 KB slot per unit
   function automatic sad_sel_t peri_slot(input logic [7:0] idx);
      unique case (idx)
         8'h00:   peri_slot = SEL_WDT0;
         8'h04:   peri_slot = SEL_GPIOA;
         8'h05:   peri_slot = SEL_GPIOB;
         8'h06:   peri_slot = SEL_GPIOC;
         8'h07:   peri_slot = SEL_GPIOD;
         8'h08:   peri_slot = SEL_SSI0;
         8'h0c:   peri_slot = SEL_UART0;
         8'h0d:   peri_slot = SEL_UART1;
         8'h0e:   peri_slot = SEL_UART2;
         8'h20:   peri_slot = SEL_I2C0;
         8'h24:   peri_slot = SEL_GPIOE;
         8'h25:   peri_slot = SEL_GPIOF;
         8'h26:   peri_slot = SEL_GPIOG;
         8'h30:   peri_slot = SEL_TMR0;
         8'h31:   peri_slot = SEL_TMR1;
         8'h32:   peri_slot = SEL_TMR2;
         8'h33:   peri_slot = SEL_TMR3;
         8'h38:   peri_slot = SEL_ADC0;
         8'h3c:   peri_slot = SEL_ACMP;
         8'hfc:   peri_slot = SEL_HIB;
         8'hfd:   peri_slot = SEL_FCTL;
         8'hfe:   peri_slot = SEL_SYSCTL;
         default: peri_slot = SEL_NONE;
      endcase
   endfunction
endpackage

// ===== tb/sad_core_model.sv
// Purpose: Bus master model that issues one request at a time
// Assumes: Called just after a rising clock edge
// Notes:   Request fields are inverted once taken, so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module sad_core_model
   import sad_pkg::*;
(
   input  wire logic              clk,        // System clock
   output var  logic              req_valid,  // Request present
   output var  sad_pkg::sad_req_t req,        // Request fields
   input  wire logic              req_ready,  // Decoder idle
   input  wire logic              rsp_valid,  // Response pulse
   input  wire sad_pkg::sad_rsp_t rsp         // Response fields
);
   initial begin
      req_valid = 1'b0;
      req       = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic access(input logic w, input logic [1:0] sz, input logic [31:0] a,
                         input logic [63:0] wd, output sad_rsp_t r);
      int n;
      req_valid = 1'b1;
      req       = '{write: w, size: sz, addr: a, wdata: wd};
      for (n = 0; n < 100 && req_ready !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      req       = ~req;
      r         = 'x;
      for (n = 0; n < 100; n++) begin
         if (rsp_valid === 1'b1) begin
            r = rsp;
            break;
         end
         @(posedge clk);
         #1;
      end
      // Let an edge pass so the next request never lands in this time step
      @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// ===== tb/system_address_decoder_bench.sv
// Purpose: Self-checking bench for the system address decoder
// Assumes: Target side answered here from a shadow word memory
// Notes:   Random mix of direct, alias, reserved and faulted accesses
`timescale 1ns/1ps
`default_nettype none
module system_address_decoder_bench;
   import sad_pkg::*;
   typedef struct packed {
      sad_sel_t    sel;
      logic [19:0] offset;
      logic        write;
      logic [3:0]  strb;
      logic [31:0] wdata;
      logic        lock;
   } sad_exp_t;

   logic        clk, rst, req_valid, req_ready, rsp_valid, tgt_valid, tgt_lock;
   logic        tgt_ack, tgt_err, inj;
   logic [31:0] tgt_rdata;
   sad_req_t    req;
   sad_rsp_t    rsp;
   sad_tgt_t    tgt;
   int          n_errors, num_checks;
   sad_exp_t    q[$];
   logic [31:0] mem[int];
   logic [31:0] dir[20] = '{32'h0, 32'h3f000, 32'h40000, 32'h20000000, 32'h2000f000,
      32'h20010000, 32'h40001000, 32'h400ff000, 32'h44000000, 32'he0000000, 32'he0001000,
      32'he0002000, 32'he0003000, 32'he000e000, 32'he000f000, 32'he0040000, 32'he0041000,
      32'he0100000, 32'h60000000, 32'hfffff000};
   logic [7:0]  pidx[22] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0c, 8'h0d,
      8'h0e, 8'h20, 8'h24, 8'h25, 8'h26, 8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h3c, 8'hfc,
      8'hfd, 8'hfe};
   sad_sel_t    psel[22] = '{SEL_WDT0, SEL_GPIOA, SEL_GPIOB, SEL_GPIOC, SEL_GPIOD,
      SEL_SSI0, SEL_UART0, SEL_UART1, SEL_UART2, SEL_I2C0, SEL_GPIOE, SEL_GPIOF,
      SEL_GPIOG, SEL_TMR0, SEL_TMR1, SEL_TMR2, SEL_TMR3, SEL_ADC0, SEL_ACMP, SEL_HIB,
      SEL_FCTL, SEL_SYSCTL};

   sad_decoder sad_decoder_i (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .tgt_valid(tgt_valid),
      .tgt(tgt), .tgt_lock(tgt_lock), .tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata),
      .tgt_err(tgt_err));
   sad_core_model sad_core_model_i (.clk(clk), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      if (n_errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   function automatic logic [31:0] rd(sad_sel_t s, logic [19:0] o);
      int k = int'({s, o[19:2]});
      return mem.exists(k) ? mem[k] : 32'(k * 32'h9e3779b1);
   endfunction

   // Reference map of the whole 4 GB space
   function automatic void dec(input logic [31:0] a, output sad_sel_t s,
                               output logic [19:0] o);
      s = SEL_NONE;
      o = {8'h0, a[11:0]};
      if (a < 32'h40000) begin
         s = SEL_FLASH;
         o = {2'h0, a[17:0]};
      end else if (a[31:16] == 16'h2000) begin
         s = SEL_SRAM;
         o = {4'h0, a[15:0]};
      end else if (a[31:20] == 12'h400) begin
         for (int i = 0; i < 22; i++) if (a[19:12] == pidx[i]) s = psel[i];
      end else if (a[31:12] == 20'he0000) s = SEL_SWTRACE;
      else if (a[31:12] == 20'he0001) s = SEL_WPTRACE;
      else if (a[31:12] == 20'he0002) s = SEL_PATCHBP;
      else if (a[31:12] == 20'he000e) s = SEL_COREPER;
      else if (a[31:12] == 20'he0040) s = SEL_TRACEPORT;
   endfunction

   task automatic op(input logic w, input logic [1:0] sz, input logic [31:0] a,
                     input logic [63:0] wd);
      sad_sel_t    s;
      logic [19:0] o;
      logic [31:0] wa, off, old, w2;
      logic [63:0] er;
      logic [3:0]  st;
      logic        f, al;
      sad_rsp_t    r;
      al = (a[31:21] == 11'h110) || (a[31:25] == 7'h21);
      wa = a;
      off = a & 32'h01ffffff;
      if (al) wa = (a[30] ? 32'h40000000 : 32'h20000000) + ((off >> 5) & ~32'h3);
      dec(wa, s, o);
      f = (s == SEL_NONE) || (!al && ((sz == 2'h1 && a[0]) || (sz[1] && a[1:0] != 2'h0)));
      er = '0;
      if (!f && al) begin
         old = rd(s, o);
         er[0] = old[off[6:2]];
         q.push_back('{s, o, 1'b0, 4'hf, 32'h0, w});
         old[off[6:2]] = wd[0];
         if (w && !inj) q.push_back('{s, o, 1'b1, 4'hf, old, 1'b1});
      end else if (!f) begin
         for (int i = 0; i < (sz == 2'h3 ? 2 : 1); i++) begin
            st = sz == 2'h0 ? 4'h1 << a[1:0] : sz == 2'h1 ? 4'h3 << a[1:0] : 4'hf;
            w2 = sz == 2'h3 ? wd[32 * i +: 32] : 32'(wd << (8 * a[1:0]));
            if (i == 0 || !inj) q.push_back('{s, o + 20'(4 * i), w, st, w ? w2 : 32'h0, 1'b0});
            old = rd(s, o + 20'(4 * i));
            er[32 * i +: 32] = old >> (8 * a[1:0]);
         end
         if (sz == 2'h0) er &= 64'hff;
         else if (sz == 2'h1) er &= 64'hffff;
      end
      sad_core_model_i.access(w, sz, a, wd, r);
      check(64'(r.err), 64'(f | inj));
      if (!w && !f && !inj) check(r.rdata, er);
      check(64'(q.size()), 64'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Target side: random wait, then one-cycle ack
   initial begin
      int d;
      logic [31:0] v;
      logic [63:0] got, want;
      tgt_ack = 1'b0;
      tgt_err = 1'b0;
      tgt_rdata = 32'h0;
      forever begin
         @(posedge clk);
         #1;
         if (tgt_valid === 1'b1) begin
            d = $urandom % 3;
            for (int i = 0; i < d; i++) begin
               @(posedge clk);
               #1;
            end
            got = 64'({tgt.sel, tgt.offset, tgt.write, tgt.strb,
                       tgt.write ? tgt.wdata : 32'h0, tgt_lock});
            want = q.size() ? 64'(q.pop_front()) : '1;
            check(got, want);
            v = rd(tgt.sel, tgt.offset);
            for (int j = 0; j < 4; j++) begin
               if (tgt.write && tgt.strb[j]) begin
                  v[8 * j +: 8] = tgt.wdata[8 * j +: 8];
               end
            end
            if (tgt.write) mem[int'({tgt.sel, tgt.offset[19:2]})] = v;
            tgt_rdata = v;
            tgt_err = inj;
            tgt_ack = 1'b1;
            @(posedge clk);
            #1;
            tgt_ack = 1'b0;
            tgt_rdata = ~tgt_rdata;
            tgt_err = ~tgt_err;
         end
      end
   end

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      #100000;
      n_errors++;
      complete_run;
   end

   initial begin
      logic [31:0] a;
      logic [1:0]  sz;
      int          k;
      rst = 1'b1;
      inj = 1'b0;
      n_errors = 0;
      num_checks = 0;
      void'($urandom(32'hb878));
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      for (int n = 0; n < 560; n++) begin
         inj = n >= 520;
         k = $urandom % 4;
         sz = 2'($urandom);
         a = k == 0 ? dir[$urandom % 20] : k == 1 ? 32'h22000000 + ($urandom & 32'h1fffff) :
             k == 2 ? 32'h42000000 + ($urandom & 32'h1ffffff) :
             32'h40000000 + {12'h0, pidx[$urandom % 22], 12'h0};
         if (k == 0 || k == 3) a += $urandom & (sz == 2'h3 ? 32'h7ff : 32'hfff);
         op(1'($urandom), sz, a, {$urandom, $urandom});
      end
      complete_run;
   end
endmodule
`default_nettype wire
